// [pkg/access_err_params.svh]
// Register map, field positions, reset values of the access error event block.
// Assumes a 32-bit APB slave port with byte addresses and aligned words.
`ifndef ACCESS_ERR_PARAMS_SVH
`define ACCESS_ERR_PARAMS_SVH

// ---------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------
`define AEE_ADDR_W          8
`define AEE_DATA_W          32

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define AEE_OFF_EVENT_CTRL  8'h04
`define AEE_OFF_INTEN_CLR   8'h08
`define AEE_OFF_INTEN_SET   8'h0c
`define AEE_OFF_FLAG_BASE   8'h10
`define AEE_FLAG_STRIDE     8'h08
`define AEE_MASK_DELTA      8'h04

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define AEE_BIT_EVENT_OE    0
`define AEE_BIT_INTEN       0
`define AEE_EVENT_CTRL_RST  1'b0
`define AEE_INTEN_RST       1'b0
`define AEE_FLAG_RST        32'h0000_0000
`define AEE_MASK_RST        32'hffff_ffff

`endif

// [pkg/access_err_pkg.sv]
// Types shared by the access error event block and its bus port.
// Assumes the constants header is on the include path.
`include "access_err_params.svh"

package access_err_pkg;

    typedef logic [`AEE_ADDR_W-1:0] addr_t;
    typedef logic [`AEE_DATA_W-1:0] data_t;

    typedef enum {
        SEL_NONE,
        SEL_EVENT_CTRL,
        SEL_INTEN_CLR,
        SEL_INTEN_SET,
        SEL_FLAGS,
        SEL_MASK
    } reg_sel_t;

endpackage

// [pkg/reg_access_if.sv]
// Internal register access path between the APB port and the register file.
// Assumes both ends run on the same clock.
interface reg_access_if;
    import access_err_pkg::*;

    logic  wr_en;
    addr_t addr;
    data_t wdata;
    data_t rdata;
    logic  hit;

    modport port (output wr_en, output addr, output wdata, input rdata, input hit);
    modport regs (input wr_en, input addr, input wdata, output rdata, output hit);
endinterface

// [logic/apb_reg_port.sv]
// APB slave front end: one wait-free access phase, registered answer.
// Assumes a well-behaved APB master on the same clock as the registers.
module apb_reg_port
    import access_err_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  psel,
    input  wire logic  penable,
    input  wire logic  pwrite,
    input  wire addr_t paddr,
    input  wire data_t pwdata,
    output logic       pready,
    output data_t      prdata,
    output logic       pslverr,
    reg_access_if.port bus
);

    logic setup;

    assign setup     = psel && !penable;
    assign bus.addr  = paddr;
    assign bus.wdata = pwdata;
    // Write lands only on the edge that completes the access phase
    assign bus.wr_en = psel && penable && pready && pwrite;

    // ---------------------------------------------------------------
    // Answer registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Read data captured at setup; unmapped offsets answer with an error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? '0 : bus.rdata;
            pslverr <= !bus.hit;
        end
    end

endmodule

// [logic/access_error_event_ctrl.sv]
// Access error flags, event output and interrupt enable for the
// peripheral access controller, with an APB register port.
// Assumes error inputs are single-clock pulses from logic on REF_CLK.
`include "access_err_params.svh"

module access_error_event_ctrl
    import access_err_pkg::*;
#(
    parameter int FLAG_WIDTH   = 8,
    parameter int BRIDGE_COUNT = 3
)(
    input  wire logic                             REF_CLK,
    input  wire logic                             RESET_N,
    input  wire logic                             PSEL,
    input  wire logic                             PENABLE,
    input  wire logic                             PWRITE,
    input  wire addr_t                            PADDR,
    input  wire data_t                            PWDATA,
    output data_t                                 PRDATA,
    output logic                                  PREADY,
    output logic                                  PSLVERR,
    input  wire logic [FLAG_WIDTH-1:0]            HOST_BUS_ERR,
    input  wire logic [BRIDGE_COUNT*FLAG_WIDTH-1:0] BRIDGE_ERR,
    output logic                                  ACCESS_ERR_EVENT,
    output logic                                  ACCESS_ERR_IRQ
);

    localparam int NUM_FLAG_REGS = BRIDGE_COUNT + 1;

    // ---------------------------------------------------------------
    // Parameter checks
    // ---------------------------------------------------------------
    // Up to 4 bridges keep the highest offset at 0x34, inside the 8-bit address space
    if (FLAG_WIDTH < 1 || FLAG_WIDTH > 32) begin : g_bad_width
        $error("FLAG_WIDTH must be 1 to 32");
    end
    if (BRIDGE_COUNT < 1 || BRIDGE_COUNT > 4) begin : g_bad_count
        $error("BRIDGE_COUNT must be 1 to 4");
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic reg_sel_t decode_kind(input addr_t a);
        addr_t rel;
        rel = a - `AEE_OFF_FLAG_BASE;
        if (a[1:0] != 2'b00) begin
            return SEL_NONE;
        end
        case (a)
            `AEE_OFF_EVENT_CTRL: return SEL_EVENT_CTRL;
            `AEE_OFF_INTEN_CLR:  return SEL_INTEN_CLR;
            `AEE_OFF_INTEN_SET:  return SEL_INTEN_SET;
            default: begin
                if (a < `AEE_OFF_FLAG_BASE) begin
                    return SEL_NONE;
                end
                if (32'(rel / `AEE_FLAG_STRIDE) >= NUM_FLAG_REGS) begin
                    return SEL_NONE;
                end
                return (rel[2:0] == 3'(`AEE_MASK_DELTA)) ? SEL_MASK : SEL_FLAGS;
            end
        endcase
    endfunction

    function automatic int flag_index(input addr_t a);
        addr_t rel;
        rel = a - `AEE_OFF_FLAG_BASE;
        return 32'(rel / `AEE_FLAG_STRIDE);
    endfunction

    // ---------------------------------------------------------------
    // Bus port
    // ---------------------------------------------------------------
    reg_access_if bus ();

    apb_reg_port u_port (
        .clk     (REF_CLK),
        .rst_n   (RESET_N),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .pready  (PREADY),
        .prdata  (PRDATA),
        .pslverr (PSLVERR),
        .bus     (bus.port)
    );

    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    int       wr_idx;
    int       rd_idx;

    assign wr_sel = bus.wr_en ? decode_kind(bus.addr) : SEL_NONE;
    assign wr_idx = flag_index(bus.addr);
    assign rd_sel = decode_kind(bus.addr);
    assign rd_idx = flag_index(bus.addr);

    // ---------------------------------------------------------------
    // Control state
    // ---------------------------------------------------------------
    logic event_oe_r;
    logic inten_r;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            event_oe_r <= `AEE_EVENT_CTRL_RST;
        end else if (wr_sel == SEL_EVENT_CTRL) begin
            event_oe_r <= bus.wdata[`AEE_BIT_EVENT_OE];
        end
    end

    // One enable behind both the set and the clear view
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            inten_r <= `AEE_INTEN_RST;
        end else if (wr_sel == SEL_INTEN_SET && bus.wdata[`AEE_BIT_INTEN]) begin
            inten_r <= 1'b1;
        end else if (wr_sel == SEL_INTEN_CLR && bus.wdata[`AEE_BIT_INTEN]) begin
            inten_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Error flags and masks
    // ---------------------------------------------------------------
    logic [FLAG_WIDTH-1:0] err_in  [NUM_FLAG_REGS];
    logic [FLAG_WIDTH-1:0] flag_r  [NUM_FLAG_REGS];
    logic [FLAG_WIDTH-1:0] mask_r  [NUM_FLAG_REGS];
    logic [NUM_FLAG_REGS-1:0] new_set;
    logic [NUM_FLAG_REGS-1:0] pending;

    assign err_in[0] = HOST_BUS_ERR;

    for (genvar k = 0; k < NUM_FLAG_REGS; k++) begin : g_flags
        logic [FLAG_WIDTH-1:0] clr_bits;

        if (k > 0) begin : g_bridge
            assign err_in[k] = BRIDGE_ERR[(k-1)*FLAG_WIDTH +: FLAG_WIDTH];
        end

        assign clr_bits   = (wr_sel == SEL_FLAGS && wr_idx == k) ?
                            bus.wdata[FLAG_WIDTH-1:0] : '0;
        assign new_set[k] = |(err_in[k] & ~flag_r[k]);
        assign pending[k] = |(flag_r[k] & mask_r[k]);

        // Setting wins over a same-cycle write-one-to-clear
        always_ff @(posedge REF_CLK) begin
            if (!RESET_N) begin
                flag_r[k] <= FLAG_WIDTH'(`AEE_FLAG_RST);
            end else begin
                flag_r[k] <= (flag_r[k] & ~clr_bits) | err_in[k];
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (!RESET_N) begin
                mask_r[k] <= FLAG_WIDTH'(`AEE_MASK_RST);
            end else if (wr_sel == SEL_MASK && wr_idx == k) begin
                mask_r[k] <= bus.wdata[FLAG_WIDTH-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Event and interrupt outputs
    // ---------------------------------------------------------------
    // Fires on the 0-to-1 transition only; a bit held set gives no repeat
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ACCESS_ERR_EVENT <= 1'b0;
        end else begin
            ACCESS_ERR_EVENT <= event_oe_r && (|new_set);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ACCESS_ERR_IRQ <= 1'b0;
        end else begin
            ACCESS_ERR_IRQ <= inten_r && (|pending);
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    always_comb begin
        bus.rdata = '0;
        bus.hit   = 1'b1;
        case (rd_sel)
            SEL_EVENT_CTRL: bus.rdata[`AEE_BIT_EVENT_OE] = event_oe_r;
            SEL_INTEN_CLR:  bus.rdata[`AEE_BIT_INTEN]    = inten_r;
            SEL_INTEN_SET:  bus.rdata[`AEE_BIT_INTEN]    = inten_r;
            SEL_FLAGS:      bus.rdata[FLAG_WIDTH-1:0]    = flag_r[rd_idx];
            SEL_MASK:       bus.rdata[FLAG_WIDTH-1:0]    = mask_r[rd_idx];
            default:        bus.hit                      = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    logic was_reset_r;

    always_ff @(posedge REF_CLK) begin
        was_reset_r <= !RESET_N;
    end

    a_event_on_set: assert property (
        event_oe_r && (|new_set) |=> ACCESS_ERR_EVENT
    ) else $error("Flag set while enabled gave no event");

    a_event_gated: assert property (
        !event_oe_r |=> !ACCESS_ERR_EVENT
    ) else $error("Event left while output disabled");

    a_reset_off: assert property (
        was_reset_r |-> !event_oe_r && !ACCESS_ERR_EVENT
    ) else $error("Event output enabled after reset");

    a_clr_zero_keeps: assert property (
        (wr_sel == SEL_INTEN_CLR) && !bus.wdata[`AEE_BIT_INTEN]
            |=> inten_r == $past(inten_r)
    ) else $error("Writing zero to enable clear changed the enable");

    a_clr_one_stops: assert property (
        (wr_sel == SEL_INTEN_CLR) && bus.wdata[`AEE_BIT_INTEN]
            |=> !inten_r ##1 !ACCESS_ERR_IRQ
    ) else $error("Clear write did not stop the interrupt");

    a_shared_enable: assert property (
        (wr_sel == SEL_INTEN_SET) && bus.wdata[`AEE_BIT_INTEN]
            |=> inten_r
    ) else $error("Set write not seen by the shared enable");

    a_read_enable: assert property (
        PSEL && !PENABLE && !PWRITE && PADDR == `AEE_OFF_INTEN_CLR
            |=> PRDATA[`AEE_BIT_INTEN] == $past(inten_r) && PREADY
    ) else $error("Enable clear read returned the wrong state");

    a_irq_level: assert property (
        ##1 ACCESS_ERR_IRQ == $past(inten_r && (|pending))
    ) else $error("Interrupt level does not follow enable and flags");

endmodule

// [testbench/test_access_error_event_ctrl.sv]
// Self-checking bench for the access error event block: APB, event, interrupt.
// Assumes the package, the constants header and the design are compiled first.
module test_access_error_event_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import access_err_pkg::*;

    logic        ref_clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    addr_t       paddr;
    data_t       pwdata;
    data_t       prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  host_err;
    logic [23:0] bridge_err;
    logic        ev;
    logic        irq;
    integer      seed = 32'h5d42954f;
    int          err_total = 0;
    int          compares = 0;
    bit          rnd_on = 0;
    bit          live = 0;
    int          g;
    int          k;
    int          ra[12] = '{4, 8, 12, 16, 20, 24, 28, 32, 36, 40, 44, 0};
    // Model: group 0 is the host bus, 1..3 the bridges
    int          m_en, m_ie, ev_exp, irq_exp;
    int          m_flag[4];
    int          m_mask[4];

    access_error_event_ctrl #(.FLAG_WIDTH(8), .BRIDGE_COUNT(3)) access_error_event_ctrl_i (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .HOST_BUS_ERR(host_err),
        .BRIDGE_ERR(bridge_err), .ACCESS_ERR_EVENT(ev), .ACCESS_ERR_IRQ(irq));

    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ---------------------------------------------------------------
    // Reference model, stepped on every rising edge
    // ---------------------------------------------------------------
    // Writes counted at the edge that completes them, as the slave sees it
    always @(posedge ref_clk) begin : model
        int e;
        int clr;
        bit wr;
        wr = psel && penable && pready && pwrite && !bad_addr(paddr);
        if (!reset_n) begin
            {m_en, m_ie, ev_exp, irq_exp} = 0;
            for (int i = 0; i < 4; i++) begin
                m_flag[i] = 0;
                m_mask[i] = 8'hff;
            end
        end else begin
            {ev_exp, irq_exp} = 0;
            for (int i = 0; i < 4; i++) begin
                e = (i == 0) ? host_err : bridge_err[(i-1)*8 +: 8];
                if (m_en != 0 && (e & ~m_flag[i]) != 0) ev_exp = 1;
                if (m_ie != 0 && (m_flag[i] & m_mask[i]) != 0) irq_exp = 1;
                clr = (wr && paddr == 16 + 8*i) ? pwdata : 0;
                // Set wins over a clear in the same cycle
                m_flag[i] = ((m_flag[i] & ~clr) | e) & 8'hff;
                if (wr && paddr == 20 + 8*i) m_mask[i] = pwdata & 8'hff;
            end
            if (wr && paddr == 4) m_en = pwdata & 1;
            if (wr && paddr == 8 && (pwdata & 1) != 0) m_ie = 0;
            if (wr && paddr == 12 && (pwdata & 1) != 0) m_ie = 1;
        end
    end

    function automatic bit bad_addr(int a);
        return !(a == 4 || a == 8 || a == 12 || (a >= 16 && a <= 44 && a % 4 == 0));
    endfunction

    function automatic int exp_rd(int a);
        if (bad_addr(a)) return 0;
        if (a == 4) return m_en;
        if (a == 8 || a == 12) return m_ie;
        return ((a - 16) % 8 == 0) ? m_flag[(a-16)/8] : m_mask[(a-16)/8];
    endfunction

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // ---------------------------------------------------------------
    // APB master: setup, access held until pready sampled high
    // ---------------------------------------------------------------
    task automatic apb(bit wr, int a, int d);
        int          n;
        bit          er;
        logic [31:0] rv;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a[7:0];
        pwdata <= d;
        @(negedge ref_clk);
        rv = exp_rd(a);
        er = bad_addr(a);
        @(posedge ref_clk);
        penable <= 1;
        n = 0;
        @(posedge ref_clk);
        // Answer taken at the rising edge that samples pready high
        while (pready !== 1'b1) begin
            n++;
            @(posedge ref_clk);
        end
        check("pready waits", 0, n);
        check("pslverr", er, pslverr);
        if (!wr) check("prdata", rv, prdata);
        psel <= 0;
        penable <= 0;
    endtask

    task automatic pulse(int grp, int b);
        @(posedge ref_clk);
        if (grp == 0) host_err <= 8'h1 << b;
        else bridge_err <= 24'h1 << ((grp - 1) * 8 + b);
        @(posedge ref_clk);
        host_err <= 0;
        bridge_err <= 0;
    endtask

    task automatic done_t(string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(negedge ref_clk) if (live) begin
        check("event", ev_exp, ev);
        check("irq", irq_exp, irq);
    end

    // Sparse random error pulses, also landing during bus transfers
    always @(posedge ref_clk) if (rnd_on) begin
        host_err <= (($random(seed) & 7) == 0) ? 8'h1 << ($random(seed) & 7) : 8'h0;
        bridge_err <= (($random(seed) & 7) == 0) ? 24'h1 << ({$random(seed)} % 24) : 24'h0;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("unexpected timeout: expected end of tests, seen none");
        report_and_stop();
    end

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, host_err, bridge_err} = 0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1;
        live = 1;
        foreach (ra[i]) apb(0, ra[i], 0);
        done_t("reset values");
        pulse(0, 2);
        apb(1, 4, 1);
        for (g = 0; g < 4; g++) pulse(g, g + 3);
        pulse(0, 2);
        pulse(2, 4);
        apb(0, 4, 0);
        done_t("event output");
        apb(1, 12, 1);
        apb(0, 8, 0);
        apb(1, 8, 0);
        apb(0, 12, 0);
        apb(1, 8, 1);
        apb(0, 8, 0);
        apb(0, 12, 0);
        apb(1, 12, 1);
        apb(1, 20, 0);
        for (g = 1; g < 4; g++) apb(1, 16 + 8*g, 32'hffff_ffff);
        apb(1, 20, 32'h0000_00ff);
        apb(1, 16, 32'h0000_00ff);
        apb(1, 0, 32'hffff_ffff);
        apb(1, 5, 32'hffff_ffff);
        apb(0, 48, 0);
        apb(0, 4, 0);
        done_t("interrupt enable");
        rnd_on = 1;
        repeat (300) begin
            k = {$random(seed)} % 12;
            apb($random(seed) & 1, ra[k], $random(seed));
        end
        rnd_on = 0;
        @(posedge ref_clk);
        host_err <= 0;
        bridge_err <= 0;
        repeat (4) @(posedge ref_clk);
        done_t("random traffic");
        report_and_stop();
    end
endmodule
